// *** design/atn_agc.sv ***
// AGC loop accumulator in limit-code units with 23 fraction bits.
// Assumes magnitude samples share the processing clock.
module atn_agc
   import atn_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Engine carrier
   atn_core_if.agc core
);
   logic [ACC_W-1:0] acc;
   logic [13:0] mag_scaled;
   logic signed [14:0] err;
   logic signed [19:0] prod;
   logic signed [36:0] delta;
   logic signed [36:0] sum;
   logic signed [36:0] up_full;
   logic signed [36:0] lo_full;
   logic [ACC_W-1:0] next_acc;
   // Magnitude times 1.59375, close to the 1.6 the loop expects
   assign mag_scaled = {1'b0, core.mag} + {2'b00, core.mag[12:1]}
                     + {5'b00000, core.mag[12:4]}
                     + {6'b000000, core.mag[12:5]};
   assign err = $signed({{2{core.threshold[12]}}, core.threshold})
              - $signed({1'b0, mag_scaled});
   assign prod = err * $signed({1'b0, core.mant});
   // 1.5 dB is 64 code steps, folded into the fixed shift
   assign delta = 37'(prod) <<< core.expo;
   assign sum = $signed({2'b00, acc}) + delta;
   assign up_full = $signed({2'b00, core.upper, 23'h000000});
   assign lo_full = $signed({2'b00, core.lower, 23'h000000});
   assign next_acc = (sum > up_full) ? up_full[ACC_W-1:0] :
                     (sum < lo_full) ? lo_full[ACC_W-1:0] :
                     sum[ACC_W-1:0];
   assign core.gain = acc[ACC_W-1:FRAC_W];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc <= '0;
      end else if (core.clk_en) begin
         if (core.agc_sync) begin
            acc <= {core.upper, 23'h000000};
         end else if (core.mag_valid) begin
            acc <= next_acc;
         end
      end
   end
   chk_agc_step_sign: assert property (@(posedge clk) disable iff (sys_rst)
      core.clk_en && core.mag_valid && !core.agc_sync && err > 0
      && core.mant != 4'h0 && core.lower <= core.upper
      |=> acc >= $past(acc))
      else $error("AGC gain fell on positive error");
endmodule // atn_agc

// *** design/atn_core_if.sv ***
// Carrier between the control top and its AGC and NCO engines.
// Assumes the top drives all configuration from its registers.
interface atn_core_if;
   logic clk_en;
   logic [12:0] threshold;
   logic [3:0] mant;
   logic [3:0] expo;
   logic [11:0] upper;
   logic [11:0] lower;
   logic agc_sync;
   logic [12:0] mag;
   logic mag_valid;
   logic [11:0] gain;
   logic [31:0] freq_hold;
   logic [7:0] phase_hold;
   logic freq_load;
   logic phase_load;
   logic nco_sync;
   logic clr_acc;
   logic load_on_update;
   logic ofs_en;
   logic [1:0] ofs_code;
   logic [31:0] ofs_in;
   logic [31:0] freq_act;
   logic [7:0] phase_act;
   logic [31:0] phase_out;
   modport agc (input clk_en, threshold, mant, expo, upper, lower,
                agc_sync, mag, mag_valid, output gain);
   modport nco (input clk_en, freq_hold, phase_hold, freq_load,
                phase_load, nco_sync, clr_acc, load_on_update, ofs_en,
                ofs_code, ofs_in, output freq_act, phase_act, phase_out);
endinterface

// *** design/atn_ctl.sv ***
// Top of the AGC and timing NCO control words with an Avalon-MM slave.
// Assumes clk is the processing clock; both pins are asynchronous.
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
module atn_ctl
   import atn_pkg::*;
(
   // Clock, enable and reset
   input wire logic clk,
   input wire logic clk_en,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Device pins
   input wire logic filter_sync_input,
   input wire logic loop_gain_select_pin,
   // Datapath on the processing clock
   input wire logic [12:0] mag_in,
   input wire logic mag_valid,
   input wire logic [31:0] offset_freq_in,
   // Results
   output logic [11:0] agc_gain_level,
   output logic [31:0] timing_phase
);
   // -------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------
   function automatic logic atn_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
      atn_hit = (a == off);
   endfunction

   atn_bus_t bus_st;
   logic [31:0] agc_cfg;
   logic [31:0] agc_lim;
   logic [31:0] nco_opt;
   logic [31:0] freq_hold;
   logic [7:0] phase_hold;
   logic [11:0] gain_hold;
   logic freq_stb;
   logic phase_stb;
   logic smp_stb;
   logic sync_prev;

   wire bus_req = avs_read | avs_write;
   wire wr_take = (bus_st == ATN_ANSWER) & avs_write;
   wire hit_cfg = atn_hit(avs_address, OFF_AGC_CFG);
   wire hit_lim = atn_hit(avs_address, OFF_AGC_LIM);
   wire hit_smp = atn_hit(avs_address, OFF_AGC_SMP);
   wire hit_opt = atn_hit(avs_address, OFF_NCO_OPT);
   wire hit_frq = atn_hit(avs_address, OFF_NCO_FRQ);
   wire hit_fstb = atn_hit(avs_address, OFF_NCO_FSTB);
   wire hit_phs = atn_hit(avs_address, OFF_NCO_PHS);
   wire hit_pstb = atn_hit(avs_address, OFF_NCO_PSTB);
   wire hit_hold = atn_hit(avs_address, OFF_AGC_HOLD);
   wire hit_act = atn_hit(avs_address, OFF_NCO_ACT);

   atn_core_if core ();

   // -------------------------------------------------------------
   // Read data selection
   // -------------------------------------------------------------
   // Strobe words and unmapped offsets read as zero
   wire [31:0] rd_mux =
      hit_cfg ? agc_cfg :
      hit_lim ? agc_lim :
      hit_opt ? nco_opt :
      hit_frq ? freq_hold :
      hit_phs ? {24'h000000, phase_hold} :
      hit_hold ? {20'h00000, gain_hold} :
      hit_act ? core.freq_act :
      32'h0000_0000;

   // -------------------------------------------------------------
   // Bus answer: one wait cycle, then the request is taken
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus_st <= ATN_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else if (clk_en) begin
         case (bus_st)
            ATN_IDLE: begin
               if (bus_req) begin
                  bus_st <= ATN_ANSWER;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
               end
            end
            ATN_ANSWER: begin
               bus_st <= ATN_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_st <= ATN_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Control words, all in the processing clock domain
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         agc_cfg <= RST_AGC_CFG;
         agc_lim <= RST_AGC_LIM;
         nco_opt <= RST_NCO_OPT;
         freq_hold <= '0;
         phase_hold <= '0;
      end else if (clk_en && wr_take) begin
         if (hit_cfg) begin
            agc_cfg <= avs_writedata & MSK_AGC_CFG;
         end
         if (hit_lim) begin
            agc_lim <= avs_writedata & MSK_AGC_LIM;
         end
         if (hit_opt) begin
            nco_opt <= avs_writedata & MSK_NCO_OPT;
         end
         if (hit_frq) begin
            freq_hold <= avs_writedata;
         end
         if (hit_phs) begin
            phase_hold <= avs_writedata[7:0];
         end
      end
   end

   // Strobes last one cycle, registered so they act after the write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         freq_stb <= 1'b0;
         phase_stb <= 1'b0;
         smp_stb <= 1'b0;
      end else if (clk_en) begin
         freq_stb <= wr_take & hit_fstb;
         phase_stb <= wr_take & hit_pstb;
         smp_stb <= wr_take & hit_smp;
      end
   end

   // -------------------------------------------------------------
   // Gain sample hold
   // -------------------------------------------------------------
   // Holding the value lets software read a word that cannot tear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gain_hold <= '0;
      end else if (clk_en && smp_stb) begin
         gain_hold <= core.gain;
      end
   end

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   wire pin_raw [2];
   logic [2:0] pin_sh [2];
   logic pin_lvl [2];
   assign pin_raw[0] = filter_sync_input;
   assign pin_raw[1] = loop_gain_select_pin;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_pin
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               pin_sh[i] <= 3'h0;
               pin_lvl[i] <= 1'b0;
            end else if (clk_en) begin
               pin_sh[i] <= {pin_sh[i][1:0], pin_raw[i]};
               // A change counts only once stages two and three agree
               if (pin_sh[i][2] == pin_sh[i][1]) begin
                  pin_lvl[i] <= pin_sh[i][2];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_prev <= 1'b0;
      end else if (clk_en) begin
         sync_prev <= pin_lvl[0];
      end
   end

   wire sync_pulse = pin_lvl[0] & ~sync_prev;
   wire gain_sel = pin_lvl[1];

   // -------------------------------------------------------------
   // Engine configuration
   // -------------------------------------------------------------
   assign core.clk_en = clk_en;
   assign core.threshold = agc_cfg[THR_MSB:THR_LSB];
   assign core.mant = gain_sel ? agc_cfg[G1_M_LSB +: 4]
                               : agc_cfg[G0_M_LSB +: 4];
   assign core.expo = gain_sel ? agc_cfg[G1_E_LSB +: 4]
                               : agc_cfg[G0_E_LSB +: 4];
   assign core.upper = agc_lim[UL_LSB +: 12];
   assign core.lower = agc_lim[LL_LSB +: 12];
   assign core.agc_sync = sync_pulse & agc_cfg[AGC_SYNC_BIT];
   assign core.mag = mag_in;
   assign core.mag_valid = mag_valid;
   assign core.freq_hold = freq_hold;
   assign core.phase_hold = phase_hold;
   assign core.freq_load = freq_stb;
   assign core.phase_load = phase_stb;
   assign core.nco_sync = sync_pulse & nco_opt[NCO_SYNC_BIT];
   assign core.clr_acc = nco_opt[CLR_BIT];
   assign core.load_on_update = nco_opt[LOU_BIT];
   assign core.ofs_en = nco_opt[OFE_BIT];
   assign core.ofs_code = nco_opt[OFW_LSB +: 2];
   assign core.ofs_in = offset_freq_in;

   atn_agc u_agc (
      .clk(clk),
      .sys_rst(sys_rst),
      .core(core.agc)
   );

   atn_nco u_nco (
      .clk(clk),
      .sys_rst(sys_rst),
      .core(core.nco)
   );

   // Both results are flops inside the engines
   assign agc_gain_level = core.gain;
   assign timing_phase = core.phase_out;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_bus_one_wait: assert property (
      clk_en && bus_st == ATN_IDLE && bus_req
      |=> !avs_waitrequest ##1 (!clk_en || avs_waitrequest))
      else $error("Bus answer not after one wait cycle");

   chk_cfg_write: assert property (
      clk_en && wr_take && hit_cfg
      |=> agc_cfg == ($past(avs_writedata) & MSK_AGC_CFG))
      else $error("AGC word write lost");

   chk_sync_agc_load: assert property (
      clk_en && sync_pulse && agc_cfg[AGC_SYNC_BIT]
      |=> agc_gain_level == $past(agc_lim[UL_LSB +: 12]))
      else $error("Sync did not load AGC accumulator");

   chk_sync_agc_off: assert property (
      clk_en && sync_pulse && !agc_cfg[AGC_SYNC_BIT] && !mag_valid
      |=> $stable(agc_gain_level))
      else $error("Sync moved AGC with sync bit clear");

   chk_gain_sel_high: assert property (
      gain_sel && !$past(sys_rst) |-> core.mant == agc_cfg[15:12]
      && core.expo == agc_cfg[11:8])
      else $error("Loop gain one not selected");

   chk_gain_sel_low: assert property (
      !gain_sel |-> core.mant == agc_cfg[7:4]
      && core.expo == agc_cfg[3:0])
      else $error("Loop gain zero not selected");

   chk_gain_upper: assert property (
      clk_en && mag_valid && !core.agc_sync && core.lower <= core.upper
      |=> agc_gain_level <= $past(core.upper))
      else $error("Gain above upper limit");

   chk_gain_lower: assert property (
      clk_en && mag_valid && !core.agc_sync && core.lower <= core.upper
      |=> agc_gain_level >= $past(core.lower))
      else $error("Gain below lower limit");

   chk_sample_hold: assert property (
      clk_en && wr_take && hit_smp ##1 clk_en
      |=> gain_hold == $past(agc_gain_level))
      else $error("Sample strobe did not capture gain");

   chk_hold_stable: assert property (
      clk_en && !smp_stb |=> $stable(gain_hold))
      else $error("Held gain changed without strobe");

   chk_freq_strobe: assert property (
      clk_en && wr_take && hit_fstb ##1 clk_en
      |=> core.freq_act == $past(freq_hold))
      else $error("Frequency strobe did not load active");

   chk_nco_sync_on: assert property (
      clk_en && sync_pulse && nco_opt[NCO_SYNC_BIT]
      |=> core.freq_act == $past(freq_hold)
      && core.phase_act == $past(phase_hold))
      else $error("Sync did not load NCO actives");

   chk_nco_sync_off: assert property (
      clk_en && sync_pulse && !nco_opt[NCO_SYNC_BIT] && !freq_stb
      |=> $stable(core.freq_act))
      else $error("Sync moved NCO with sync bit clear");
endmodule // atn_ctl

// *** design/atn_nco.sv ***
// Timing NCO active registers and phase accumulator.
// Assumes offset frequency comes from logic on the same clock.
module atn_nco
   import atn_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Engine carrier
   atn_core_if.nco core
);
   logic [31:0] acc;
   logic [31:0] ofs;
   logic zero_fb;
   logic [31:0] next_acc;
   assign zero_fb = core.clr_acc
      | (core.load_on_update & (core.freq_load | core.nco_sync));
   assign ofs = core.ofs_en ? atn_ofs_ext(core.ofs_in, core.ofs_code)
                            : 32'h0000_0000;
   assign next_acc = (zero_fb ? 32'h0000_0000 : acc) + core.freq_act + ofs;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc <= '0;
         core.freq_act <= '0;
         core.phase_act <= '0;
         core.phase_out <= '0;
      end else if (core.clk_en) begin
         acc <= next_acc;
         core.phase_out <= next_acc + {core.phase_act, 24'h000000};
         if (core.freq_load || core.nco_sync) begin
            core.freq_act <= core.freq_hold;
         end
         if (core.phase_load || core.nco_sync) begin
            core.phase_act <= core.phase_hold;
         end
      end
   end
   chk_clear_feedback: assert property (@(posedge clk) disable iff (sys_rst)
      core.clk_en && zero_fb |=> acc == $past(core.freq_act) + $past(ofs))
      else $error("Accumulator feedback not zeroed");
   chk_offset_zero: assert property (@(posedge clk) disable iff (sys_rst)
      core.clk_en && !core.ofs_en && !zero_fb
      |=> acc == $past(acc) + $past(core.freq_act))
      else $error("Disabled offset reached adder");
endmodule // atn_nco

// *** design/atn_pkg.sv ***
// Constants, field layout and helpers for the AGC and timing NCO controls.
// Assumes a single processing clock and a word-aligned register bus.
// Operation
// - AGC sync bit lets sync input load accumulator
// - Gain error is threshold minus magnitude
// - Threshold is signed, MSB bit 28, ten fraction bits
// - Select pin high uses loop gain one fields
// - Step scales error by mantissa and exponent
// - Mantissa is unsigned fraction over sixteen
// - Select pin low uses loop gain zero fields
// - Upper limit caps gain, exponent plus mantissa
// - Limit code is log gain, linear steps
// - Sample strobe freezes loop output for reading
// - NCO sync bit lets sync load actives
// - Two-bit code picks 8 to 32 offset bits
// - Offset enable off feeds zero offset
// - Clear bit zeroes accumulator feedback
// - Load-on-update zeroes feedback on a frequency strobe or sync load
// - All control words act on processing clock
// - Frequency strobe copies held frequency to active
package atn_pkg;
   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFF_AGC_CFG = 6'h00;
   localparam logic [5:0] OFF_AGC_LIM = 6'h04;
   localparam logic [5:0] OFF_AGC_SMP = 6'h08;
   localparam logic [5:0] OFF_NCO_OPT = 6'h0C;
   localparam logic [5:0] OFF_NCO_FRQ = 6'h10;
   localparam logic [5:0] OFF_NCO_FSTB = 6'h14;
   localparam logic [5:0] OFF_NCO_PHS = 6'h18;
   localparam logic [5:0] OFF_NCO_PSTB = 6'h1C;
   localparam logic [5:0] OFF_AGC_HOLD = 6'h20;
   localparam logic [5:0] OFF_NCO_ACT = 6'h24;
   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int AGC_SYNC_BIT = 29;
   localparam int THR_MSB = 28;
   localparam int THR_LSB = 16;
   localparam int G1_M_LSB = 12;
   localparam int G1_E_LSB = 8;
   localparam int G0_M_LSB = 4;
   localparam int G0_E_LSB = 0;
   localparam int UL_LSB = 16;
   localparam int LL_LSB = 0;
   localparam int NCO_SYNC_BIT = 5;
   localparam int OFW_LSB = 3;
   localparam int OFE_BIT = 2;
   localparam int CLR_BIT = 1;
   localparam int LOU_BIT = 0;
   // -------------------------------------------------------------
   // Reset values and writable masks
   // -------------------------------------------------------------
   localparam logic [31:0] RST_AGC_CFG = 32'h0000_0000;
   localparam logic [31:0] RST_AGC_LIM = 32'h0FFF_0000;
   localparam logic [31:0] RST_NCO_OPT = 32'h0000_0000;
   localparam logic [31:0] MSK_AGC_CFG = 32'h3FFF_FFFF;
   localparam logic [31:0] MSK_AGC_LIM = 32'h0FFF_0FFF;
   localparam logic [31:0] MSK_NCO_OPT = 32'h0000_003F;
   localparam logic [31:0] MSK_NCO_PHS = 32'h0000_00FF;
   localparam int FRAC_W = 23;
   localparam int ACC_W = 35;
   typedef enum logic [0:0] {ATN_IDLE = 1'b0, ATN_ANSWER = 1'b1} atn_bus_t;
   // Offset word sign-extended from the selected number of low bits
   function automatic logic [31:0] atn_ofs_ext(input logic [31:0] v,
                                              input logic [1:0] code);
      case (code)
         2'b00: atn_ofs_ext = {{24{v[7]}}, v[7:0]};
         2'b01: atn_ofs_ext = {{16{v[15]}}, v[15:0]};
         2'b10: atn_ofs_ext = {{8{v[23]}}, v[23:0]};
         default: atn_ofs_ext = v;
      endcase
   endfunction
endpackage

// *** sim/atn_host.sv ***
// Host processor model: an Avalon-MM master issuing word transfers.
// Assumes the slave answers by dropping waitrequest for one cycle.
module atn_host
   import atn_pkg::*;
(
   // Clock
   input wire logic clk,
   // Avalon-MM master
   output logic [ADDR_W-1:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
   end
   // -------------------------------------------------------------
   // One transfer, held until waitrequest is seen low at an edge
   // -------------------------------------------------------------
   // No wait limit here; the bench's cycle ceiling ends a hang
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge clk iff avs_waitrequest === 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
endmodule // atn_host

// *** sim/tb_top.sv ***
// Self-checking bench for the AGC and timing NCO control words.
// Assumes one processing clock and the host model as bus master.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import atn_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, sync_pin = 1'b0, gsel = 1'b0;
   logic mag_valid = 1'b0;
   logic [12:0] mag = '0;
   logic [31:0] ofs = '0, q, wd, rdata;
   logic [ADDR_W-1:0] a;
   logic rd, wr, wait_r;
   logic [11:0] gain;
   logic [31:0] tp, tp0;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   localparam logic [31:0] F1 = 32'h0012_3457;
   localparam logic [31:0] F2 = 32'h0000_1000;
   always #10 clk = ~clk;
   atn_ctl dut(.clk(clk), .clk_en(1'b1), .sys_rst(sys_rst),
      .avs_address(a), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_readdata(rdata), .avs_waitrequest(wait_r),
      .filter_sync_input(sync_pin), .loop_gain_select_pin(gsel),
      .mag_in(mag), .mag_valid(mag_valid), .offset_freq_in(ofs),
      .agc_gain_level(gain), .timing_phase(tp));
   atn_host host(.clk(clk), .avs_address(a), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
      .avs_waitrequest(wait_r));
   // -------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wrr(input logic [5:0] ad, input logic [31:0] d);
      host.xfer(1'b1, ad, d, q);
   endtask
   task automatic rdc(input logic [5:0] ad, input logic [31:0] e);
      host.xfer(1'b0, ad, '0, q);
      check(q, e);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Pin goes through a synchroniser, so allow it time to land
   task automatic pulse_sync;
      @(posedge clk) sync_pin <= 1'b1;
      wait_n(2);
      sync_pin <= 1'b0;
      wait_n(8);
   endtask
   task automatic step_agc(input int n);
      repeat (n) begin
         @(posedge clk) mag_valid <= 1'b1;
         @(posedge clk) mag_valid <= 1'b0;
         wait_n(2);
      end
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_regs;
      rdc(OFF_AGC_CFG, 32'h0000_0000);
      rdc(OFF_AGC_LIM, 32'h0FFF_0000);
      rdc(OFF_NCO_OPT, 32'h0000_0000);
      rdc(6'h3C, 32'h0000_0000);
      wrr(OFF_AGC_CFG, 32'hFFFF_FFFF);
      rdc(OFF_AGC_CFG, 32'h3FFF_FFFF);
      wrr(OFF_NCO_OPT, 32'hFFFF_FFFF);
      rdc(OFF_NCO_OPT, 32'h0000_003F);
      rdc(OFF_AGC_SMP, 32'h0000_0000);
      wrr(OFF_AGC_CFG, 32'h0000_0000);
      wrr(OFF_NCO_OPT, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_agc;
      check(gain, 32'h0);
      pulse_sync;
      check(gain, 32'h0);
      wrr(OFF_AGC_CFG, 32'h2000_0000);
      pulse_sync;
      check(gain, 32'hFFF);
      wrr(OFF_AGC_SMP, 32'h0);
      rdc(OFF_AGC_HOLD, 32'hFFF);
      wrr(OFF_AGC_LIM, 32'h0800_0100);
      // Negative threshold with a large magnitude drives gain down
      wrr(OFF_AGC_CFG, 32'h3000_FF00);
      pulse_sync;
      check(gain, 32'h800);
      mag <= 13'h05A8;
      step_agc(2);
      check(gain, 32'h800);
      gsel <= 1'b1;
      wait_n(6);
      step_agc(8);
      check(gain, 32'h100);
      mag <= 13'h0000;
      wrr(OFF_AGC_CFG, 32'h0FFF_FF00);
      step_agc(8);
      check(gain, 32'h800);
      $display("test agc done");
   endtask
   task automatic t_nco;
      logic signed [31:0] t;
      wrr(OFF_NCO_FRQ, F1);
      wrr(OFF_NCO_FSTB, 32'h0);
      rdc(OFF_NCO_ACT, F1);
      wrr(OFF_NCO_FRQ, F2);
      pulse_sync;
      rdc(OFF_NCO_ACT, F1);
      wrr(OFF_NCO_OPT, 32'h20);
      pulse_sync;
      rdc(OFF_NCO_ACT, F2);
      wrr(OFF_NCO_FRQ, F1);
      wrr(OFF_NCO_FSTB, 32'h0);
      ofs <= 32'h8080_8080;
      wrr(OFF_NCO_OPT, 32'h1A);
      wait_n(3);
      check(tp, F1);
      for (int c = 0; c < 4; c++) begin
         wrr(OFF_NCO_OPT, 32'h6 | (c << 3));
         wait_n(3);
         t = ofs << (24 - 8 * c);
         t = t >>> (24 - 8 * c);
         check(tp, F1 + t);
      end
      wrr(OFF_NCO_OPT, 32'h0);
      @(negedge clk) tp0 = tp;
      @(negedge clk);
      check(tp - tp0, F1);
      wrr(OFF_NCO_OPT, 32'h1);
      wrr(OFF_NCO_FSTB, 32'h0);
      wait_n(2);
      check(32'(tp <= 8 * F1), 32'h1);
      $display("test nco done");
   endtask
   // -------------------------------------------------------------
   // Flow, ceiling and verdict
   // -------------------------------------------------------------
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   initial begin
      wait_n(8);
      sys_rst <= 1'b0;
      wait_n(2);
      t_regs;
      t_agc;
      t_nco;
      wrap_up;
   end
endmodule // tb_top
